// ---- rtl/pin_select_pkg.sv ----
// Package for the port-2/port-3 output function selector.
// Assumes an APB register bus of 32-bit aligned words on a single clock.
package pin_select_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] TIMER_CTRL0_OFS = 8'h00;
    localparam logic [7:0] TIMER_CTRL1_OFS = 8'h04;
    localparam logic [7:0] SERIAL_CTRL_OFS = 8'h08;
    localparam logic [7:0] PULSE_EN_OFS = 8'h0C;
    localparam logic [7:0] DMA_CTRL_OFS = 8'h10;
    localparam logic [7:0] PORT_DIR_OFS = 8'h14;
    localparam logic [7:0] PORT_DATA_OFS = 8'h18;
    localparam logic [7:0] PIN_STATUS_OFS = 8'h1C;

    // ****************************************************************
    // Field positions (low bit of each field)
    // ****************************************************************
    // Timer control 0: four 4-bit io-control fields, then buffer modes
    localparam int T0A_POS = 0;
    localparam int T0B_POS = 4;
    localparam int T0C_POS = 8;
    localparam int T0D_POS = 12;
    localparam int BUF_A_POS = 16;
    localparam int BUF_B_POS = 17;
    // Timer control 1
    localparam int T1A_POS = 0;
    localparam int T1B_POS = 4;
    localparam int T2A_POS = 8;
    localparam int T2B_POS = 12;
    localparam int T3B_POS = 16;
    // Serial control
    localparam int SMART_POS = 0;
    localparam int GSM_POS = 1;
    localparam int SYNC_POS = 2;
    localparam int TE_POS = 3;
    localparam int RE_POS = 4;
    localparam int CKE_POS = 5;
    // DMA control: channel 0 at bit 0, channel 1 at bit 8
    localparam int DMA1_POS = 8;
    localparam int LOC_POS = 0;
    localparam int AMS_POS = 2;
    localparam int ACKE_POS = 3;
    localparam int TENDE_POS = 4;
    // Port direction, data, status: port-2 bit 0 at 0, port-3 at 15..8
    localparam int P2_POS = 0;
    localparam int P3_POS = 8;
    localparam int ALT_POS = 16;

    // ****************************************************************
    // Encodings and reset values
    // ****************************************************************
    localparam logic [1:0] LOC_SECOND = 2'h1;
    localparam logic [1:0] CKE_INT_OUT = 2'h1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [2:0] SYNC_RESET = 3'h0;

    // Peripheral outputs offered to the pins
    typedef struct packed {
        logic timer3_chan_b_out;
        logic timer2_chan_b_out;
        logic timer2_chan_a_out;
        logic timer1_chan_b_out;
        logic timer1_chan_a_out;
        logic timer0_chan_d_out;
        logic timer0_chan_c_out;
        logic timer0_chan_b_out;
        logic timer0_chan_a_out;
        logic serial0_clock_out;
        logic dma1_acknowledge;
        logic dma0_acknowledge;
        logic dma1_transfer_end;
        logic dma0_transfer_end;
        logic [15:0] pulse_out;
    } periph_out_t;

    // One pad: level driven, and drive enable (low while driving)
    typedef struct packed {
        logic out;
        logic oe_n;
    } pad_drive_t;

endpackage

// ---- rtl/port_out_select.sv ----
// Output function selector for port-2 bit 0 and port-3 bits 7..0.
// Assumes peripherals on pclk drive periph_out; pads are resolved outside.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps

// Functional notes
// RULE1: P2.0 takes timer3 B compare when enabled
// RULE2: Smart card: P2.0 serial clock per GSM/clock
// RULE3: Normal serial: P2.0 clock in async/sync cases
// RULE4: Pulse bits drive pins when enable set
// RULE5: P3.7 takes timer2 B compare when enabled
// RULE6: P3.6 takes timer2 A compare when enabled
// RULE7: P3.5 takes timer1 B compare when enabled
// RULE8: P3.4 takes timer1 A compare when enabled
// RULE9: P3.3 timer0 D needs B buffer off
// RULE10: P3.2 timer0 C needs A buffer off
// RULE11: P3.1 takes timer0 B compare when enabled
// RULE12: P3.0 takes timer0 A compare when enabled
// RULE13: DMA acknowledge on P3.5 and P3.2
// RULE14: DMA transfer end on P3.4 and P3.1
// RULE15: No alternate: port direction and data rule
// RULE16: First listed active function wins per pin; the code puts pulse bits lowest and DMA strobes above timers on port 3
module port_out_select (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral outputs
    input pin_select_pkg::periph_out_t periph_out,
    // Port-2 bit 0 pad
    input wire logic p2_pin_in,
    output logic p2_pin_out,
    output logic p2_pin_oe_n,
    // Port-3 pads
    input wire logic [7:0] p3_pin_in,
    output logic [7:0] p3_pin_out,
    output logic [7:0] p3_pin_oe_n
);
    import pin_select_pkg::*;

    // Compare output is enabled: control bit 3 clear, action nonzero
    function automatic logic compare_on(input logic [3:0] f);
        compare_on = !f[3] && (f[1:0] != 2'h0);
    endfunction

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [31:0] tctl0_q, tctl1_q, sctl_q, pen_q, dctl_q, dir_q, dat_q;
    logic [31:0] prdata_q, rd_mux;
    logic rd_hit;
    logic pslverr_q;
    wire setup = psel && !penable;
    wire wr_acc = psel && penable && pwrite;

    // Registers are written at the access edge; zero-wait slave
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tctl0_q <= CTRL_RESET;
            tctl1_q <= CTRL_RESET;
            sctl_q <= CTRL_RESET;
            pen_q <= CTRL_RESET;
            dctl_q <= CTRL_RESET;
            dir_q <= CTRL_RESET;
            dat_q <= CTRL_RESET;
        end else if (wr_acc) begin
            case (paddr)
                TIMER_CTRL0_OFS: tctl0_q <= pwdata;
                TIMER_CTRL1_OFS: tctl1_q <= pwdata;
                SERIAL_CTRL_OFS: sctl_q <= pwdata;
                PULSE_EN_OFS: pen_q <= pwdata;
                DMA_CTRL_OFS: dctl_q <= pwdata;
                PORT_DIR_OFS: dir_q <= pwdata;
                PORT_DATA_OFS: dat_q <= pwdata;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Pin input synchronisers
    // ****************************************************************
    // Three stages; the filtered level only moves when stages 2 and 3 agree
    logic [8:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 9'h000;
            pin_s2_q <= 9'h000;
            pin_s3_q <= 9'h000;
            pin_lvl_q <= 9'h000;
        end else begin
            pin_s1_q <= {p3_pin_in, p2_pin_in};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            for (int i = 0; i < 9; i++) begin
                if (pin_s2_q[i] == pin_s3_q[i]) begin
                    pin_lvl_q[i] <= pin_s3_q[i];
                end
            end
        end
    end

    // ****************************************************************
    // Enable conditions
    // ****************************************************************
    wire [3:0] t0a = tctl0_q[T0A_POS +: 4];
    wire [3:0] t0b = tctl0_q[T0B_POS +: 4];
    wire [3:0] t0c = tctl0_q[T0C_POS +: 4];
    wire [3:0] t0d = tctl0_q[T0D_POS +: 4];
    wire chan_a_buffer_mode = tctl0_q[BUF_A_POS];
    wire chan_b_buffer_mode = tctl0_q[BUF_B_POS];

    // Timer compare enables
    wire t3b_en = compare_on(tctl1_q[T3B_POS +: 4]);  // see RULE1
    wire t2b_en = compare_on(tctl1_q[T2B_POS +: 4]);  // see RULE5
    wire t2a_en = compare_on(tctl1_q[T2A_POS +: 4]);  // see RULE6
    wire t1b_en = compare_on(tctl1_q[T1B_POS +: 4]);  // see RULE7
    wire t1a_en = compare_on(tctl1_q[T1A_POS +: 4]);  // see RULE8
    wire t0d_en = !chan_b_buffer_mode && compare_on(t0d);  // see RULE9
    // Channel C checked against its own field, not channel D's
    wire t0c_en = !chan_a_buffer_mode && compare_on(t0c);  // see RULE10
    wire t0b_en = compare_on(t0b);  // see RULE11
    wire t0a_en = compare_on(t0a);  // see RULE12

    // Serial clock output enable
    wire smart_card_select = sctl_q[SMART_POS];
    wire gsm_mode_bit = sctl_q[GSM_POS];
    wire clocked_sync_select = sctl_q[SYNC_POS];
    wire txrx_on = sctl_q[TE_POS] || sctl_q[RE_POS];
    wire [1:0] serial_clock_source_field = sctl_q[CKE_POS +: 2];
    wire cke_out = serial_clock_source_field == CKE_INT_OUT;
    wire sck_smart = txrx_on && ((!gsm_mode_bit && cke_out) || gsm_mode_bit);  // see RULE2
    wire sck_norm = txrx_on && ((!clocked_sync_select && cke_out)
        || (clocked_sync_select && !serial_clock_source_field[1]));  // see RULE3
    wire sck_en = smart_card_select ? sck_smart : sck_norm;

    // Pulse enables: low bit 0 and high bits 15..8
    wire pulse_enable_low = pen_q[0];
    wire [7:0] pulse_enable_high = pen_q[15:8];

    // DMA strobe enables
    wire [1:0] dma0_pin_location = dctl_q[LOC_POS +: 2];
    wire [1:0] dma1_pin_location = dctl_q[DMA1_POS + LOC_POS +: 2];
    wire d0_here = dma0_pin_location == LOC_SECOND;
    wire d1_here = dma1_pin_location == LOC_SECOND;
    wire ack0_en = d0_here && dctl_q[AMS_POS] && dctl_q[ACKE_POS];  // see RULE13
    wire ack1_en = d1_here && dctl_q[DMA1_POS + AMS_POS]
        && dctl_q[DMA1_POS + ACKE_POS];  // see RULE13
    wire dma0_transfer_end_en = d0_here && dctl_q[TENDE_POS];  // see RULE14
    wire dma1_transfer_end_en = d1_here && dctl_q[DMA1_POS + TENDE_POS];  // see RULE14

    // ****************************************************************
    // Per-pin selection
    // ****************************************************************
    // Fixed priority: the last assigned active function owns the pin
    pad_drive_t p2_d;
    pad_drive_t [7:0] p3_d;
    logic [8:0] alt_on;
    always_comb begin
        // Default is the plain port: drive data when direction is output
        p2_d = '{out: dat_q[P2_POS], oe_n: !dir_q[P2_POS]};  // see RULE15
        for (int i = 0; i < 8; i++) begin
            p3_d[i] = '{out: dat_q[P3_POS + i], oe_n: !dir_q[P3_POS + i]};  // see RULE15
        end
        // Port-2 bit 0; later assignments win, so test in reverse
        if (pulse_enable_low) p2_d = '{out: periph_out.pulse_out[0], oe_n: 1'b0};  // see RULE4
        if (sck_en) p2_d = '{out: periph_out.serial0_clock_out, oe_n: 1'b0};  // see RULE16
        if (t3b_en) p2_d = '{out: periph_out.timer3_chan_b_out, oe_n: 1'b0};  // see RULE16
        // Pulse outputs lowest on every port-3 pin
        for (int i = 0; i < 8; i++) begin
            if (pulse_enable_high[i]) begin
                p3_d[i] = '{out: periph_out.pulse_out[8 + i], oe_n: 1'b0};  // see RULE4
            end
        end
        if (t2b_en) p3_d[7] = '{out: periph_out.timer2_chan_b_out, oe_n: 1'b0};
        if (t2a_en) p3_d[6] = '{out: periph_out.timer2_chan_a_out, oe_n: 1'b0};
        if (t1b_en) p3_d[5] = '{out: periph_out.timer1_chan_b_out, oe_n: 1'b0};
        if (ack1_en) p3_d[5] = '{out: periph_out.dma1_acknowledge, oe_n: 1'b0};  // see RULE16
        if (t1a_en) p3_d[4] = '{out: periph_out.timer1_chan_a_out, oe_n: 1'b0};
        if (dma1_transfer_end_en) p3_d[4] = '{out: periph_out.dma1_transfer_end, oe_n: 1'b0};  // see RULE16
        if (t0d_en) p3_d[3] = '{out: periph_out.timer0_chan_d_out, oe_n: 1'b0};
        if (t0c_en) p3_d[2] = '{out: periph_out.timer0_chan_c_out, oe_n: 1'b0};
        if (ack0_en) p3_d[2] = '{out: periph_out.dma0_acknowledge, oe_n: 1'b0};  // see RULE16
        if (t0b_en) p3_d[1] = '{out: periph_out.timer0_chan_b_out, oe_n: 1'b0};
        if (dma0_transfer_end_en) p3_d[1] = '{out: periph_out.dma0_transfer_end, oe_n: 1'b0};  // see RULE16
        if (t0a_en) p3_d[0] = '{out: periph_out.timer0_chan_a_out, oe_n: 1'b0};
        // Alternate-function ownership, reported in the status register
        alt_on[0] = t3b_en || sck_en || pulse_enable_low;
        alt_on[8] = t2b_en || pulse_enable_high[7];
        alt_on[7] = t2a_en || pulse_enable_high[6];
        alt_on[6] = ack1_en || t1b_en || pulse_enable_high[5];
        alt_on[5] = dma1_transfer_end_en || t1a_en || pulse_enable_high[4];
        alt_on[4] = t0d_en || pulse_enable_high[3];
        alt_on[3] = ack0_en || t0c_en || pulse_enable_high[2];
        alt_on[2] = dma0_transfer_end_en || t0b_en || pulse_enable_high[1];
        alt_on[1] = t0a_en || pulse_enable_high[0];
    end

    // Pads registered: one cycle of latency buys glitch-free pins
    pad_drive_t p2_q;
    pad_drive_t [7:0] p3_q;
    logic [8:0] alt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p2_q <= '{out: 1'b0, oe_n: 1'b1};
            p3_q <= {8{2'h1}};
            alt_q <= 9'h000;
        end else begin
            p2_q <= p2_d;
            p3_q <= p3_d;
            alt_q <= alt_on;
        end
    end

    assign p2_pin_out = p2_q.out;
    assign p2_pin_oe_n = p2_q.oe_n;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            p3_pin_out[i] = p3_q[i].out;
            p3_pin_oe_n[i] = p3_q[i].oe_n;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Read data captured in the setup cycle, held through the access
    always_comb begin
        rd_hit = 1'b1;
        case (paddr)
            TIMER_CTRL0_OFS: rd_mux = tctl0_q;
            TIMER_CTRL1_OFS: rd_mux = tctl1_q;
            SERIAL_CTRL_OFS: rd_mux = sctl_q;
            PULSE_EN_OFS: rd_mux = pen_q;
            DMA_CTRL_OFS: rd_mux = dctl_q;
            PORT_DIR_OFS: rd_mux = dir_q;
            PORT_DATA_OFS: rd_mux = dat_q;
            PIN_STATUS_OFS: rd_mux = {alt_q[8:1], 7'h00, alt_q[0],
                pin_lvl_q[8:1], 7'h00, pin_lvl_q[0]};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_q <= !rd_hit;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = pslverr_q && psel && penable;

endmodule

// ---- tb/pad_board_model.sv ----
// Board model for the selector's pads: pull-ups plus an optional low driver.
// Assumes oe_n low means the selector drives the pad.
`timescale 1ns/100ps
module pad_board_model (
    // Pad drive from the selector
    input wire logic p2_pin_out,
    input wire logic p2_pin_oe_n,
    input wire logic [7:0] p3_pin_out,
    input wire logic [7:0] p3_pin_oe_n,
    // Board driver, bit 8 is port-2 bit 0; only acts on released pads
    input wire logic [8:0] ext_low,
    // Pad levels seen back by the selector
    output logic p2_pin_in,
    output logic [7:0] p3_pin_in
);
    // A released pad floats up to the pull-up, never to its last driven level
    assign p2_pin_in = p2_pin_oe_n ? !ext_low[8] : p2_pin_out;
    assign p3_pin_in = (p3_pin_out & ~p3_pin_oe_n) | (~ext_low[7:0] & p3_pin_oe_n);
endmodule

// ---- tb/port_out_select_checker.sv ----
// Concurrent checks on the pad selection of port_out_select.
// Assumes it is bound to the selector and sees only its ports.
`timescale 1ns/100ps
module port_out_select_checker (
    // Clock, reset and APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Peripherals and pads
    input pin_select_pkg::periph_out_t periph_out,
    input wire logic p2_pin_out,
    input wire logic p2_pin_oe_n,
    input wire logic [7:0] p3_pin_out,
    input wire logic [7:0] p3_pin_oe_n
);
    import pin_select_pkg::*;
    logic [31:0] r_q [0:6];
    wire wr_hit = psel && penable && pwrite && pready && paddr < PIN_STATUS_OFS
        && paddr[1:0] == 2'h0;
    // Shadow of the writable registers, updated at the same edge as the design
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 7; i++)
                r_q[i] <= CTRL_RESET;
        end else if (wr_hit) begin
            r_q[paddr[4:2]] <= pwdata;
        end
    end
    function automatic logic act(input logic [3:0] f);
        return !f[3] && f[1:0] != 2'h0;
    endfunction
    // ****************************************************************
    // Enable conditions from the shadowed fields
    // ****************************************************************
    wire [6:0] sc = r_q[2][6:0];
    wire [4:0] d1 = r_q[4][DMA1_POS+:5];
    wire [4:0] d0 = r_q[4][4:0];
    wire t3b = act(r_q[1][T3B_POS+:4]);
    wire sck = (sc[TE_POS] || sc[RE_POS]) && (sc[SMART_POS] ? (sc[GSM_POS] ||
        sc[6:5] == CKE_INT_OUT) : (sc[SYNC_POS] ? !sc[6] : sc[6:5] == CKE_INT_OUT));
    wire ack1 = d1[1:0] == LOC_SECOND && d1[AMS_POS] && d1[ACKE_POS];
    wire ack0 = d0[1:0] == LOC_SECOND && d0[AMS_POS] && d0[ACKE_POS];
    wire end0 = d0[1:0] == LOC_SECOND && d0[TENDE_POS];
    wire t0c = !r_q[0][BUF_A_POS] && act(r_q[0][T0C_POS+:4]);
    wire t0d = !r_q[0][BUF_B_POS] && act(r_q[0][T0D_POS+:4]);
    // Nothing on port 3 is claimed, so it falls back to direction and data
    wire quiet = r_q[0] == 0 && r_q[1] == 0 && r_q[3] == 0 && r_q[4] == 0;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Each pad is registered: the cause sampled at one edge shows at the next
    property p_t3b; t3b |=> !p2_pin_oe_n && p2_pin_out == $past(periph_out.timer3_chan_b_out);
    endproperty
    a_t3b: assert property (p_t3b) else $error("p2 bit 0 not on timer3 b");
    property p_sck; !t3b && sck |=> !p2_pin_oe_n
        && p2_pin_out == $past(periph_out.serial0_clock_out); endproperty
    a_sck: assert property (p_sck) else $error("p2 bit 0 not on serial clock");
    property p_po0; !t3b && !sck && r_q[3][0] |=> !p2_pin_oe_n
        && p2_pin_out == $past(periph_out.pulse_out[0]); endproperty
    a_po0: assert property (p_po0) else $error("p2 bit 0 not on pulse 0");
    property p_t2b; act(r_q[1][T2B_POS+:4]) |=> !p3_pin_oe_n[7]
        && p3_pin_out[7] == $past(periph_out.timer2_chan_b_out); endproperty
    a_t2b: assert property (p_t2b) else $error("p3 bit 7 not on timer2 b");
    property p_ack1; ack1 |=> !p3_pin_oe_n[5]
        && p3_pin_out[5] == $past(periph_out.dma1_acknowledge); endproperty
    a_ack1: assert property (p_ack1) else $error("p3 bit 5 not on dma1 ack");
    property p_t1b; !ack1 && act(r_q[1][T1B_POS+:4]) |=> !p3_pin_oe_n[5]
        && p3_pin_out[5] == $past(periph_out.timer1_chan_b_out); endproperty
    a_t1b: assert property (p_t1b) else $error("p3 bit 5 not on timer1 b");
    property p_end0; end0 |=> !p3_pin_oe_n[1]
        && p3_pin_out[1] == $past(periph_out.dma0_transfer_end); endproperty
    a_end0: assert property (p_end0) else $error("p3 bit 1 not on dma0 end");
    property p_t0c; !ack0 && t0c |=> !p3_pin_oe_n[2]
        && p3_pin_out[2] == $past(periph_out.timer0_chan_c_out); endproperty
    a_t0c: assert property (p_t0c) else $error("p3 bit 2 not on timer0 c");
    property p_t0d; !t0d && !r_q[3][11] |=> p3_pin_oe_n[3] == !$past(r_q[5][11]); endproperty
    a_t0d: assert property (p_t0d) else $error("p3 bit 3 claimed with timer0 d off");
    property p_gpio; quiet |=> p3_pin_oe_n == ~$past(r_q[5][15:8])
        && ((p3_pin_out ^ $past(r_q[6][15:8])) & ~p3_pin_oe_n) == 8'h00; endproperty
    a_gpio: assert property (p_gpio) else $error("p3 not on direction and data");
endmodule
bind port_out_select port_out_select_checker chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .periph_out(periph_out), .p2_pin_out(p2_pin_out),
    .p2_pin_oe_n(p2_pin_oe_n), .p3_pin_out(p3_pin_out), .p3_pin_oe_n(p3_pin_oe_n));

// ---- tb/port_out_select_tb_top.sv ----
// Self-checking bench for the port-2/port-3 output selector.
// Assumes the checker is bound in and pclk runs at 10 MHz.
`timescale 1ns/100ps
module port_out_select_tb_top;
    import pin_select_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr, p3_pin_in, p3_pin_out, p3_pin_oe_n;
    logic [31:0] pwdata, prdata, rd;
    logic p2_pin_in, p2_pin_out, p2_pin_oe_n;
    logic [8:0] ext_low;
    periph_out_t periph_out;
    int err_total = 0;
    int n_checks = 0;
    port_out_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_out(periph_out), .p2_pin_in(p2_pin_in),
        .p2_pin_out(p2_pin_out), .p2_pin_oe_n(p2_pin_oe_n), .p3_pin_in(p3_pin_in),
        .p3_pin_out(p3_pin_out), .p3_pin_oe_n(p3_pin_oe_n));
    pad_board_model board (.p2_pin_out(p2_pin_out), .p2_pin_oe_n(p2_pin_oe_n),
        .p3_pin_out(p3_pin_out), .p3_pin_oe_n(p3_pin_oe_n), .ext_low(ext_low),
        .p2_pin_in(p2_pin_in), .p3_pin_in(p3_pin_in));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; the wait for pready is bounded so a hang ends the run
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_total++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pads update one edge after the register write
    task automatic settle();
        @(posedge pclk);
        #1;
    endtask
    function automatic logic [31:0] oes();
        return 32'({p2_pin_oe_n, p3_pin_oe_n});
    endfunction
    function automatic logic [31:0] pads();
        return 32'({p2_pin_out, p3_pin_out} & ~{p2_pin_oe_n, p3_pin_oe_n});
    endfunction
    function automatic logic act(input logic [3:0] f);
        return !f[3] && f[1:0] != 2'h0;
    endfunction
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        for (int a = 0; a < 7; a++) begin
            apb(1'b0, 8'(a * 4), 32'h0);
            chk("reset value", CTRL_RESET, rd);
        end
        chk("reset oe_n", 32'h1FF, oes());
    endtask
    // Every io-control code on every timer field, compare outputs toggling
    task automatic t_timer();
        logic [3:0] f;
        for (int i = 0; i < 16; i++) begin
            f = 4'(i);
            periph_out <= {{9{f[2]}}, 21'h0};
            apb(1'b1, TIMER_CTRL0_OFS, {16'h0, {4{f}}});
            apb(1'b1, TIMER_CTRL1_OFS, {12'h0, {5{f}}});
            settle();
            chk("timer oe_n", 32'({9{!act(f)}}), oes());
            chk("timer out", 32'({9{act(f) & f[2]}}), pads());
        end
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, TIMER_CTRL0_OFS, {14'h0, 2'(b), 16'h1111});
            settle();
            chk("buffer oe_n", {23'h0, 5'h1F, 2'(b), 2'h0}, oes());
        end
    endtask
    // All serial settings, with pulse 0 enabled underneath the serial clock
    task automatic t_serial();
        logic [6:0] s;
        apb(1'b1, TIMER_CTRL0_OFS, 32'h0);
        apb(1'b1, PULSE_EN_OFS, 32'h1);
        periph_out <= 30'h0010_0000;
        for (int i = 0; i < 128; i++) begin
            s = 7'(i);
            apb(1'b1, SERIAL_CTRL_OFS, 32'(s));
            settle();
            // Port-2 bit 0 sits at bit 8 of the pad vector
            chk("serial pin", {23'h0, (s[3] | s[4]) & (s[0] ? (s[1] | s[6:5] == 2'h1) :
                (s[2] ? !s[6] : s[6:5] == 2'h1)), 8'h00}, pads());
        end
        apb(1'b1, SERIAL_CTRL_OFS, 32'h28);
        apb(1'b1, TIMER_CTRL1_OFS, 32'h1_0000);
        settle();
        chk("timer3 over serial", 32'h0, pads() | oes() & 32'h100);
        apb(1'b1, PULSE_EN_OFS, 32'h0);
        apb(1'b1, TIMER_CTRL1_OFS, 32'h0);
        apb(1'b1, SERIAL_CTRL_OFS, 32'h0);
        settle();
        chk("p2 released", 32'h1FF, oes());
    endtask
    // DMA strobes against active timer channels on the shared pads
    task automatic t_dma();
        logic [4:0] c;
        logic a;
        logic t;
        apb(1'b1, TIMER_CTRL1_OFS, 32'h11);
        apb(1'b1, TIMER_CTRL0_OFS, 32'h110);
        periph_out <= 30'h000F_0000;
        for (int i = 0; i < 32; i++) begin
            c = 5'(i);
            a = c[1:0] == 2'h1 && c[2] && c[3];
            t = c[1:0] == 2'h1 && c[4];
            apb(1'b1, DMA_CTRL_OFS, {19'h0, c, 3'h0, c});
            settle();
            chk("dma oe_n", 32'h1C9, oes());
            chk("dma out", 32'({3'h0, a, t, 1'b0, a, t, 1'b0}), pads());
        end
    endtask
    // Pulse high byte, then plain port, pin readback and register errors
    task automatic t_gpio();
        apb(1'b1, DMA_CTRL_OFS, 32'h0);
        apb(1'b1, TIMER_CTRL0_OFS, 32'h0);
        apb(1'b1, TIMER_CTRL1_OFS, 32'h0);
        periph_out <= 30'h0000_3C00;
        apb(1'b1, PULSE_EN_OFS, 32'h0000_A500);
        settle();
        chk("pulse oe_n", 32'h15A, oes());
        chk("pulse out", 32'h24, pads());
        // Ownership flags only; pin levels are still moving through the filter
        apb(1'b0, PIN_STATUS_OFS, 32'h0);
        chk("alt status", 32'hA500_0000, rd & 32'hFFFF_0000);
        apb(1'b1, PULSE_EN_OFS, 32'h0);
        apb(1'b1, PORT_DIR_OFS, 32'h0000_F001);
        apb(1'b1, PORT_DATA_OFS, 32'h0000_9601);
        ext_low <= 9'h003;
        settle();
        chk("port oe_n", 32'h00F, oes());
        chk("port out", 32'h190, pads());
        repeat (6) @(posedge pclk);
        apb(1'b0, PIN_STATUS_OFS, 32'h0);
        chk("pin status", 32'h0000_9C01, rd);
        apb(1'b1, PIN_STATUS_OFS, 32'hFFFF_FFFF);
        chk("status write err", 32'h0, 32'(er));
        apb(1'b0, PIN_STATUS_OFS, 32'h0);
        chk("status kept", 32'h0000_9C01, rd);
        apb(1'b1, 8'h20, 32'hFFFF_FFFF);
        chk("unmapped write err", 32'h1, 32'(er));
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped read", 32'h0, rd);
        chk("unmapped read err", 32'h1, 32'(er));
        apb(1'b0, PORT_DIR_OFS, 32'h0);
        chk("dir readback", 32'h0000_F001, rd);
    endtask
    // ****************************************************************
    // Clock and main sequence
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        periph_out = '0;
        ext_low = 9'h000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_timer();
        t_serial();
        t_dma();
        t_gpio();
        end_of_test();
    end
endmodule
